// [design/ieb_enable_bank.sv]
// interrupt enable mask bank with apb register access
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ieb_params.svh"

module ieb_enable_bank (
  input  wire logic        pclk,          // system clock, 50 MHz
  input  wire logic        presetn,       // asynchronous reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction, high for write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error for unmapped address
  input  wire logic [31:0] req_low,       // pending flags of low sources
  input  wire logic [31:0] req_high,      // pending flags of high sources
  output logic      [31:0] fwd_low,       // requests forwarded for priority
  output logic      [31:0] fwd_high,      // requests forwarded for priority
  output logic      [31:0] enable_low,    // current low enable word
  output logic      [31:0] enable_high    // current high enable word
);

  ieb_pkg::ieb_apb_req_t req;          // bundled bus request
  ieb_pkg::ieb_enables_t en;           // registered enable words
  ieb_pkg::ieb_enables_t next_en;      // next enable words
  logic [31:0]           next_prdata;  // next read data
  logic                  next_pslverr; // next error answer
  logic                  hit_low;      // address decodes the low word
  logic                  hit_high;     // address decodes the high word
  logic                  access;       // access phase of any transfer
  logic                  setup;        // setup phase of any transfer

  // bundle bus inputs
  always_comb begin
    req.sel    = psel;
    req.enable = penable;
    req.write  = pwrite;
    req.addr   = paddr;
    req.wdata  = pwdata;
  end

  // address decode; the slave never stretches a transfer
  always_comb begin
    hit_low  = (req.addr == `IEB_OFF_ENABLE_LOW);  // low enable word
    hit_high = (req.addr == `IEB_OFF_ENABLE_HIGH); // high enable word
    setup    = req.sel && !req.enable;             // first cycle of a transfer
    access   = req.sel && req.enable;              // completing cycle
    pready   = 1'b1;                               // zero wait states
  end

  // next enable words; a write lands only at the edge that completes
  // the access phase, so a setup cycle alone never disturbs the mask
  always_comb begin
    next_en = en;
    if (access && req.write) begin
      // only implemented bits take the written value
      if (hit_low) begin
        next_en.low = req.wdata & `IEB_MASK_ENABLE_LOW;
      end
      if (hit_high) begin
        next_en.high = req.wdata & `IEB_MASK_ENABLE_HIGH;
      end
    end
  end

  // read data and error answer, loaded at the end of the setup cycle so
  // that both come from flip-flops and stand through the access cycle
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      // an unmapped address answers with an error and reads zero
      next_pslverr = !(hit_low || hit_high);
      next_prdata  = 32'h00000000;
      if (!req.write) begin
        // unimplemented bits read zero
        if (hit_low) begin
          next_prdata = en.low & `IEB_MASK_ENABLE_LOW;
        end
        if (hit_high) begin
          next_prdata = en.high & `IEB_MASK_ENABLE_HIGH;
        end
      end
    end
  end

  // register the enable words; reset masks every source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en.low  <= `IEB_RST_ENABLE_LOW;
      en.high <= `IEB_RST_ENABLE_HIGH;
    end else begin
      en <= next_en;
    end
  end

  // register the bus answers; they hold until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // gate requests; flags themselves pass untouched upstream
  always_comb begin
    fwd_low     = req_low & en.low;
    fwd_high    = req_high & en.high;
    enable_low  = en.low;
    enable_high = en.high;
  end

  // assertions

  // whole low word forwards request and enable together
  a_fwd_low_mask: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low == (req_low & enable_low))
    else $error("low forwarding does not follow enables");

  // whole high word forwards request and enable together
  a_fwd_high_mask: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high == (req_high & enable_high))
    else $error("high forwarding does not follow enables");

  // low bits above capture one never hold a one
  a_low_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_low & ~`IEB_MASK_ENABLE_LOW) == 32'h00000000)
    else $error("low unimplemented bit set");

  // high unimplemented bits never hold a one
  a_high_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_high & ~`IEB_MASK_ENABLE_HIGH) == 32'h00000000)
    else $error("high unimplemented bit set");

  // a completed low write shows in the next cycle
  a_write_low_takes: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == `IEB_OFF_ENABLE_LOW)
      |=> enable_low == ($past(pwdata) & `IEB_MASK_ENABLE_LOW))
    else $error("low write not taken");

  // a completed high write shows in the next cycle
  a_write_high_takes: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == `IEB_OFF_ENABLE_HIGH)
      |=> enable_high == ($past(pwdata) & `IEB_MASK_ENABLE_HIGH))
    else $error("high write not taken");

  // high read data stands in the access cycle
  a_read_high_data: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `IEB_OFF_ENABLE_HIGH)
      |=> prdata == $past(enable_high))
    else $error("high read data wrong");

  // low read data stands in the access cycle
  a_read_low_data: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `IEB_OFF_ENABLE_LOW)
      |=> prdata == $past(enable_low))
    else $error("low read data wrong");

  // an unmapped address answers with an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr != `IEB_OFF_ENABLE_LOW && paddr != `IEB_OFF_ENABLE_HIGH)
      |=> pslverr)
    else $error("unmapped address not refused");

  // no completed write, no change of either word
  a_hold_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && pwrite) |=> $stable(enable_low) && $stable(enable_high))
    else $error("enable changed without a write");

  // timer one passes only while enabled
  a_timer_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low[`IEB_BIT_TIMER_ONE] == (req_low[`IEB_BIT_TIMER_ONE]
      && enable_low[`IEB_BIT_TIMER_ONE]))
    else $error("timer one gate wrong");

  // flash event stays masked while disabled
  a_flash_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_high[`IEB_BIT_FLASH_EVENT] |-> !fwd_high[`IEB_BIT_FLASH_EVENT])
    else $error("flash event leaked while masked");

  // capture one passes only while enabled
  a_capture_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low[`IEB_BIT_CAPTURE_ONE] == (req_low[`IEB_BIT_CAPTURE_ONE]
      && enable_low[`IEB_BIT_CAPTURE_ONE]))
    else $error("capture one gate wrong");

  // external pin zero passes only while enabled
  a_ext_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low[`IEB_BIT_EXT_PIN0] == (req_low[`IEB_BIT_EXT_PIN0]
      && enable_low[`IEB_BIT_EXT_PIN0]))
    else $error("external pin gate wrong");

  // both core soft sources pass only while enabled
  a_soft_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low[`IEB_BIT_CORE_SOFT1:`IEB_BIT_CORE_SOFT0]
      == (req_low[`IEB_BIT_CORE_SOFT1:`IEB_BIT_CORE_SOFT0]
      & enable_low[`IEB_BIT_CORE_SOFT1:`IEB_BIT_CORE_SOFT0]))
    else $error("core soft gate wrong");

  // core timer passes only while enabled
  a_core_timer_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_low[`IEB_BIT_CORE_TIMER] == (req_low[`IEB_BIT_CORE_TIMER]
      && enable_low[`IEB_BIT_CORE_TIMER]))
    else $error("core timer gate wrong");

  // i2c slave event passes only while enabled
  a_i2c_slave_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_I2C_SLAVE] == (req_high[`IEB_BIT_I2C_SLAVE]
      && enable_high[`IEB_BIT_I2C_SLAVE]))
    else $error("i2c slave gate wrong");

  // i2c collision passes only while enabled
  a_i2c_coll_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_I2C_COLL] == (req_high[`IEB_BIT_I2C_COLL]
      && enable_high[`IEB_BIT_I2C_COLL]))
    else $error("i2c collision gate wrong");

  // serial transmit passes only while enabled
  a_ser_tx_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_SER_TX] == (req_high[`IEB_BIT_SER_TX]
      && enable_high[`IEB_BIT_SER_TX]))
    else $error("serial transmit gate wrong");

  // serial receive passes only while enabled
  a_ser_rx_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_SER_RX] == (req_high[`IEB_BIT_SER_RX]
      && enable_high[`IEB_BIT_SER_RX]))
    else $error("serial receive gate wrong");

  // serial error passes only while enabled
  a_ser_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_SER_ERR] == (req_high[`IEB_BIT_SER_ERR]
      && enable_high[`IEB_BIT_SER_ERR]))
    else $error("serial error gate wrong");

  // spi receive, transmit and error pass only while enabled
  a_spi_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_SPI_RX:`IEB_BIT_SPI_ERR]
      == (req_high[`IEB_BIT_SPI_RX:`IEB_BIT_SPI_ERR]
      & enable_high[`IEB_BIT_SPI_RX:`IEB_BIT_SPI_ERR]))
    else $error("spi gate wrong");

  // both comparators pass only while enabled
  a_cmp_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_CMP_B:`IEB_BIT_CMP_A]
      == (req_high[`IEB_BIT_CMP_B:`IEB_BIT_CMP_A]
      & enable_high[`IEB_BIT_CMP_B:`IEB_BIT_CMP_A]))
    else $error("comparator gate wrong");

  // parallel port passes only while enabled
  a_parallel_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_PARALLEL] == (req_high[`IEB_BIT_PARALLEL]
      && enable_high[`IEB_BIT_PARALLEL]))
    else $error("parallel port gate wrong");

  // converter done passes only while enabled
  a_converter_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_CONVERTER] == (req_high[`IEB_BIT_CONVERTER]
      && enable_high[`IEB_BIT_CONVERTER]))
    else $error("converter gate wrong");

  // input change passes only while enabled
  a_input_change_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_INPUT_CHANGE] == (req_high[`IEB_BIT_INPUT_CHANGE]
      && enable_high[`IEB_BIT_INPUT_CHANGE]))
    else $error("input change gate wrong");

  // dma, calendar, clock fail and i2c master pass only while enabled
  a_dma_group_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_DMA3:`IEB_BIT_I2C_MASTER]
      == (req_high[`IEB_BIT_DMA3:`IEB_BIT_I2C_MASTER]
      & enable_high[`IEB_BIT_DMA3:`IEB_BIT_I2C_MASTER]))
    else $error("dma group gate wrong");

  // nothing is forwarded that no source has flagged
  a_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
    ((fwd_low & ~req_low) | (fwd_high & ~req_high)) == 32'h00000000)
    else $error("request forwarded without a flag");

  // cover the main transfers and a forwarded request

  c_write_low: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == `IEB_OFF_ENABLE_LOW);
  c_read_high: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == `IEB_OFF_ENABLE_HIGH);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pslverr);
  c_forward: cover property (@(posedge pclk) disable iff (!presetn)
    fwd_high[`IEB_BIT_DMA3]);

endmodule
`default_nettype wire

// [design/ieb_params.svh]
// register offsets, field positions, reset values and masks for the enable bank
`ifndef IEB_PARAMS_SVH
`define IEB_PARAMS_SVH

// register byte offsets on the apb bus
`define IEB_OFF_ENABLE_LOW   12'h000
`define IEB_OFF_ENABLE_HIGH  12'h004
// reset values: every source masked
`define IEB_RST_ENABLE_LOW   32'h00000000
`define IEB_RST_ENABLE_HIGH  32'h00000000
// implemented bits of each register
`define IEB_MASK_ENABLE_LOW  32'h0000003F
`define IEB_MASK_ENABLE_HIGH 32'h010FFFFF
// low register field positions
`define IEB_BIT_CORE_TIMER   0
`define IEB_BIT_CORE_SOFT0   1
`define IEB_BIT_CORE_SOFT1   2
`define IEB_BIT_EXT_PIN0     3
`define IEB_BIT_TIMER_ONE    4
`define IEB_BIT_CAPTURE_ONE  5
// high register field positions
`define IEB_BIT_INPUT_CHANGE 0
`define IEB_BIT_CONVERTER    1
`define IEB_BIT_PARALLEL     2
`define IEB_BIT_CMP_A        3
`define IEB_BIT_CMP_B        4
`define IEB_BIT_SPI_ERR      5
`define IEB_BIT_SPI_TX       6
`define IEB_BIT_SPI_RX       7
`define IEB_BIT_SER_ERR      8
`define IEB_BIT_SER_RX       9
`define IEB_BIT_SER_TX       10
`define IEB_BIT_I2C_COLL     11
`define IEB_BIT_I2C_SLAVE    12
`define IEB_BIT_I2C_MASTER   13
`define IEB_BIT_CLOCK_FAIL   14
`define IEB_BIT_CALENDAR     15
`define IEB_BIT_DMA0         16
`define IEB_BIT_DMA3         19
`define IEB_BIT_FLASH_EVENT  24

`endif

// [design/ieb_pkg.sv]
// types shared by the interrupt enable bank
package ieb_pkg;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ieb_apb_req_t;

  // both enable words carried together
  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } ieb_enables_t;

endpackage

// [tb/ieb_enable_bank_bench.sv]
// self-checking bench for the interrupt enable bank
`timescale 1ns/10ps
`default_nettype none
`include "ieb_params.svh"

module ieb_enable_bank_bench;
  logic        pclk;        // bench clock, 20 ns
  logic        presetn;     // reset, active low
  logic        psel;        // apb select
  logic        penable;     // apb access phase
  logic        pwrite;      // apb direction
  logic [11:0] paddr;       // apb address
  logic [31:0] pwdata;      // apb write data
  logic [31:0] prdata;      // apb read data
  logic        pready;      // apb ready
  logic        pslverr;     // apb error
  logic [31:0] req_lo;      // source flags, low word
  logic [31:0] req_hi;      // source flags, high word
  logic [31:0] fwd_lo;      // forwarded, low word
  logic [31:0] fwd_hi;      // forwarded, high word
  logic [31:0] en_lo;       // enable word, low
  logic [31:0] en_hi;       // enable word, high
  int          num_errors;  // mismatches
  int          n_tests;     // comparisons
  logic [31:0] rd;          // last read data
  logic        err;         // last error flag

  ieb_enable_bank ieb_enable_bank_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_low(req_lo), .req_high(req_hi),
    .fwd_low(fwd_lo), .fwd_high(fwd_hi), .enable_low(en_lo), .enable_high(en_hi)
  );

  // free-running clock
  always #10 pclk = ~pclk;

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write both words, read back, check gating both ways
  task automatic t_gate(input logic [31:0] p);
    apb(1'b1, `IEB_OFF_ENABLE_LOW, p);
    apb(1'b1, `IEB_OFF_ENABLE_HIGH, p);
    apb(1'b0, `IEB_OFF_ENABLE_LOW, 32'h0);
    chk(rd, p & `IEB_MASK_ENABLE_LOW);
    apb(1'b0, `IEB_OFF_ENABLE_HIGH, 32'h0);
    chk(rd, p & `IEB_MASK_ENABLE_HIGH);
    chk({31'h0, err}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    req_lo <= 32'hFFFFFFFF;
    req_hi <= 32'hFFFFFFFF;
    @(negedge pclk);
    chk(fwd_lo, p & `IEB_MASK_ENABLE_LOW);
    chk(fwd_hi, p & `IEB_MASK_ENABLE_HIGH);
    @(posedge pclk);
    req_lo <= ~p;
    req_hi <= ~p;
    @(negedge pclk);
    chk(fwd_lo | fwd_hi, 32'h0);
    @(posedge pclk);
  endtask

  // unmapped address: error, no side effect
  task automatic t_unmapped;
    apb(1'b1, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(en_lo, `IEB_MASK_ENABLE_LOW);
  endtask

  // reset in mid-run clears every enable
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(en_lo | en_hi | fwd_lo | fwd_hi, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {req_lo, req_hi, num_errors, n_tests} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(en_lo | en_hi, 32'h0);
    t_gate(32'hFFFFFFFF);
    t_unmapped();
    t_gate(32'hAAAAAAAA);
    t_gate(32'h55555555);
    t_gate(32'hFFFFFFFF);
    t_reset();
    t_gate(32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
